// file: src/mhiu_pkg.sv
// Package for the multiplier hash index unit: widths, register map, timing.
// Assumes a single 200 MHz clock domain shared by both ends.
`default_nettype none
package mhiu_pkg;
  localparam int KEY_W = 128;
  localparam int STEP_W = 16;
  localparam int OPS_MAX = 3;
  // Operand width selectors
  typedef enum logic [1:0] {
    MHIU_W48,
    MHIU_W64,
    MHIU_W128
  } mhiu_width_t;
  // Steps per width
  localparam logic [3:0] STEPS_48 = 4'h3;
  localparam logic [3:0] STEPS_64 = 4'h4;
  localparam logic [3:0] STEPS_128 = 4'h8;
  // Input and output buffer stage counts
  localparam logic [2:0] IN_BUF_CYC = 3'h2;
  localparam logic [2:0] OUT_BUF_CYC = 3'h2;
  // Fixed divisor polynomial, low 16 bits of the reduction term
  localparam logic [15:0] HASH_POLY = 16'h1021;
  // Multiplier reset values
  localparam logic [127:0] MULT_RESET = 128'h0000_0000_0000_0000_0000_0000_0000_0001;
  // Processor register map (APB byte offsets)
  localparam logic [11:0] OFF_OP48 = 12'h000;
  localparam logic [11:0] OFF_OP64 = 12'h010;
  localparam logic [11:0] OFF_OP128 = 12'h020;
  localparam logic [11:0] OFF_DONE = 12'h040;
  localparam logic [11:0] OFF_MULT48 = 12'h050;
  localparam logic [11:0] OFF_MULT64 = 12'h060;
  localparam logic [11:0] OFF_MULT128 = 12'h070;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h080;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h084;
  localparam int DONE_BIT = 0;
  localparam logic [31:0] DONE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // Interrupt status bits
  localparam int IRQ_CPU_DONE = 0;
  localparam int IRQ_ENG_DONE = 1;

  // Words of an operand set, most significant first
  function automatic logic [2:0] mhiu_words(input mhiu_width_t w);
    case (w)
      MHIU_W48: mhiu_words = 3'h2;
      MHIU_W64: mhiu_words = 3'h2;
      default: mhiu_words = 3'h4;
    endcase
  endfunction : mhiu_words

  function automatic logic [3:0] mhiu_steps(input mhiu_width_t w);
    case (w)
      MHIU_W48: mhiu_steps = STEPS_48;
      MHIU_W64: mhiu_steps = STEPS_64;
      default: mhiu_steps = STEPS_128;
    endcase
  endfunction : mhiu_steps
endpackage : mhiu_pkg
`default_nettype wire

// file: src/mhiu_if.sv
// Link between the hash unit and the engine-side requester.
// Assumes both ends run on the same clock; testbench supplies clock and reset.
`default_nettype none
interface mhiu_if (
  input wire logic clk,
  input wire logic rst_n
);
  // Command: up to three operands, one width
  logic cmd_valid;
  logic cmd_ready;
  mhiu_pkg::mhiu_width_t cmd_width;
  logic [1:0] cmd_count;
  logic [mhiu_pkg::KEY_W-1:0] cmd_op [mhiu_pkg::OPS_MAX];
  // Results back into the requester's incoming registers
  logic res_valid;
  logic [1:0] res_index;
  logic [mhiu_pkg::KEY_W-1:0] res_data;
  logic cmd_done;

  modport unit (
    input clk, rst_n, cmd_valid, cmd_width, cmd_count, cmd_op,
    output cmd_ready, res_valid, res_index, res_data, cmd_done
  );
  modport engine (
    input clk, rst_n, cmd_ready, res_valid, res_index, res_data, cmd_done,
    output cmd_valid, cmd_width, cmd_count, cmd_op
  );
endinterface : mhiu_if
`default_nettype wire

// file: src/mhiu_engine.sv
// Engine-side requester: stages up to three operands, then issues one command.
// Assumes the unit end on the other side of mhiu_if and a local user port.
`default_nettype none
module mhiu_engine (
  mhiu_if.engine LINK,
  // User request
  input wire logic REQ_VALID_IN,
  input wire logic [1:0] REQ_WIDTH_IN,
  input wire logic [1:0] REQ_COUNT_IN,
  input wire logic [mhiu_pkg::KEY_W*mhiu_pkg::OPS_MAX-1:0] REQ_OPS_IN,
  // User status
  output logic REQ_BUSY_OUT,
  output logic DONE_OUT,
  output logic [mhiu_pkg::KEY_W*mhiu_pkg::OPS_MAX-1:0] RESULTS_OUT
);
  logic busy, next_busy;
  logic done, next_done;
  logic valid, next_valid;
  mhiu_pkg::mhiu_width_t width, next_width;
  logic [1:0] count, next_count;
  logic [mhiu_pkg::KEY_W-1:0] ops [mhiu_pkg::OPS_MAX];
  logic [mhiu_pkg::KEY_W-1:0] next_ops [mhiu_pkg::OPS_MAX];
  logic [mhiu_pkg::KEY_W-1:0] res [mhiu_pkg::OPS_MAX];
  logic [mhiu_pkg::KEY_W-1:0] next_res [mhiu_pkg::OPS_MAX];

  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_valid = valid;
    next_width = width;
    next_count = count;
    next_ops = ops;
    next_res = res;
    // Operands staged contiguously before the command
    if (!busy && REQ_VALID_IN && REQ_COUNT_IN != 2'h0) begin
      next_busy = 1'b1;
      next_valid = 1'b1;
      next_width = mhiu_pkg::mhiu_width_t'(REQ_WIDTH_IN);
      next_count = REQ_COUNT_IN;
      for (int i = 0; i < mhiu_pkg::OPS_MAX; i++) begin
        next_ops[i] = REQ_OPS_IN[i*mhiu_pkg::KEY_W +: mhiu_pkg::KEY_W];
      end
    end
    if (LINK.res_valid) begin
      next_res[LINK.res_index] = LINK.res_data;
    end
    // Only the completion signal ends the wait
    // Command and operands stand until done; the unit reads later operands
    if (busy && LINK.cmd_done) begin
      next_busy = 1'b0;
      next_valid = 1'b0;
      next_done = 1'b1;
    end
  end

  always_ff @(posedge LINK.clk) begin
    if (!LINK.rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      valid <= 1'b0;
      width <= mhiu_pkg::MHIU_W48;
      count <= 2'h0;
      for (int i = 0; i < mhiu_pkg::OPS_MAX; i++) begin
        ops[i] <= '0;
        res[i] <= '0;
      end
    end else begin
      busy <= next_busy;
      done <= next_done;
      valid <= next_valid;
      width <= next_width;
      count <= next_count;
      ops <= next_ops;
      res <= next_res;
    end
  end

  // Several hashes per command keep the pipe full
  assign LINK.cmd_valid = valid;
  assign LINK.cmd_width = width;
  assign LINK.cmd_count = count;
  assign LINK.cmd_op = ops;
  assign REQ_BUSY_OUT = busy;
  assign DONE_OUT = done;
  always_comb begin
    for (int i = 0; i < mhiu_pkg::OPS_MAX; i++) begin
      RESULTS_OUT[i*mhiu_pkg::KEY_W +: mhiu_pkg::KEY_W] = res[i];
    end
  end
endmodule : mhiu_engine
`default_nettype wire

// file: src/mhiu_unit.sv
// Hash unit: engine commands over mhiu_if, processor access over APB.
// Assumes one clock, synchronous active-low reset, a well-behaved APB master.
`default_nettype none
// What this block does
// - Keys of 48, 64, 128 bits, same-width index
// - One engine command hashes up to three operands
// - Processor keeps at most one hash outstanding
// - Engine stages operands before issuing the command
// - Per-width operand sets; lowest word write starts
// - Three programmable multipliers plus fixed polynomial
// - Sixteen bits per step, result fed back
// - Three, four or eight steps by width
// - Finished index passes a two-stage output buffer
// - Engine signalled after all its hashes finish
// - Results read at operand addresses
// - Done flag clears on operand write, sets on result
// - Result read stalls until result valid
// - Latency: input buffer, array, output buffer
// - Requesters rely on done, not fixed delay
// - Polling software waits for done equal one
// - Engines should batch hashes per command
module mhiu_unit (
  mhiu_if.unit LINK,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Interrupt
  output logic IRQ_OUT
);
  typedef enum logic [2:0] {S_IDLE, S_INBUF, S_ARRAY, S_OUTBUF, S_RETURN} mhiu_state_t;
  mhiu_state_t state, next_state;
  logic [127:0] mult [3];
  logic [127:0] next_mult [3];
  logic [127:0] cpu_op [3];
  logic [127:0] next_cpu_op [3];
  logic cpu_pend, next_cpu_pend;
  mhiu_pkg::mhiu_width_t cpu_w, next_cpu_w;
  logic [31:0] done_reg, next_done_reg;
  logic [31:0] irq_stat, next_irq_stat;
  logic [31:0] irq_mask, next_irq_mask;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready;
  logic pslverr, next_pslverr;
  logic irq, next_irq;
  // Job in flight
  logic from_eng, next_from_eng;
  mhiu_pkg::mhiu_width_t jw, next_jw;
  logic [1:0] idx, next_idx;
  logic [1:0] cnt, next_cnt;
  logic [127:0] key, next_key;
  logic [127:0] acc, next_acc;
  logic [127:0] obuf [2];
  logic [127:0] next_obuf [2];
  logic [3:0] step, next_step;
  logic [2:0] tick, next_tick;
  logic ready, next_ready;
  logic res_v, next_res_v;
  logic [1:0] res_i, next_res_i;
  logic [127:0] res_d, next_res_d;
  logic cdone, next_cdone;

  function automatic logic [127:0] hstep(input logic [127:0] a, input logic [15:0] d,
                                          input logic [127:0] m, input mhiu_pkg::mhiu_width_t w);
    logic [127:0] t;
    logic [127:0] mask;
    t = (a << 16) ^ {112'h0, d};
    // Ones'-complement multiply then fold by fixed polynomial
    t = t ^ ~(m & {8{d}});
    for (int b = 0; b < 16; b++) begin
      if (t[127]) t = (t << 1) ^ {112'h0, mhiu_pkg::HASH_POLY};
      else t = t << 1;
    end
    case (w)
      mhiu_pkg::MHIU_W48: mask = {80'h0, {48{1'b1}}};
      mhiu_pkg::MHIU_W64: mask = {64'h0, {64{1'b1}}};
      default: mask = {128{1'b1}};
    endcase
    hstep = t & mask;
  endfunction : hstep

  function automatic logic [1:0] wsel(input logic [11:0] a);
    if (a >= mhiu_pkg::OFF_OP128 && a < mhiu_pkg::OFF_OP128 + 12'h010) wsel = 2'h2;
    else if (a >= mhiu_pkg::OFF_OP64 && a < mhiu_pkg::OFF_OP64 + 12'h010) wsel = 2'h1;
    else if (a < mhiu_pkg::OFF_OP48 + 12'h008) wsel = 2'h0;
    else wsel = 2'h3;
  endfunction : wsel

  logic setup;
  logic [1:0] ws;
  logic [1:0] wi;
  always_comb begin
    setup = PSEL_IN && !PENABLE_IN;
    ws = wsel(PADDR_IN);
    wi = PADDR_IN[3:2];
  end

  always_comb begin
    next_state = state;
    next_mult = mult;
    next_cpu_op = cpu_op;
    next_cpu_pend = cpu_pend;
    next_cpu_w = cpu_w;
    next_done_reg = done_reg;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_from_eng = from_eng;
    next_jw = jw;
    next_idx = idx;
    next_cnt = cnt;
    next_key = key;
    next_acc = acc;
    next_obuf = obuf;
    next_step = step;
    next_tick = tick;
    next_ready = 1'b0;
    next_res_v = 1'b0;
    next_res_i = res_i;
    next_res_d = res_d;
    next_cdone = 1'b0;
    // Hash pipeline
    case (state)
      S_IDLE: begin
        // Fixed priority: a pending processor op goes before any engine command
        if (cpu_pend) begin
          next_from_eng = 1'b0;
          next_jw = cpu_w;
          next_key = cpu_op[cpu_w];
          next_cnt = 2'h1;
          next_idx = 2'h0;
          next_state = S_INBUF;
          next_tick = 3'h0;
        end else if (LINK.cmd_valid && !cdone) begin
          // Finished command still shows valid for one cycle after done
          next_ready = 1'b1;
          next_from_eng = 1'b1;
          next_jw = LINK.cmd_width;
          next_cnt = LINK.cmd_count;
          next_idx = 2'h0;
          next_key = LINK.cmd_op[0];
          next_state = S_INBUF;
          next_tick = 3'h0;
        end
      end
      S_INBUF: begin
        next_tick = tick + 3'h1;
        if (tick + 3'h1 == mhiu_pkg::IN_BUF_CYC) begin
          next_acc = '0;
          next_step = 4'h0;
          next_state = S_ARRAY;
        end
      end
      S_ARRAY: begin
        // Most significant 16 bits first; result feeds back
        next_acc = hstep(acc, key[(mhiu_pkg::mhiu_steps(jw)-step-4'h1)*16 +: 16],
                         mult[jw], jw);
        next_obuf[0] = next_acc;
        next_step = step + 4'h1;
        if (step + 4'h1 == mhiu_pkg::mhiu_steps(jw)) begin
          next_state = S_OUTBUF;
          next_tick = 3'h0;
        end
      end
      S_OUTBUF: begin
        next_obuf[1] = obuf[0];
        next_tick = tick + 3'h1;
        if (tick + 3'h1 == mhiu_pkg::OUT_BUF_CYC) begin
          next_state = S_RETURN;
        end
      end
      S_RETURN: begin
        if (from_eng) begin
          next_res_v = 1'b1;
          next_res_i = idx;
          next_res_d = obuf[1];
          if (idx + 2'h1 >= cnt) begin
            next_cdone = 1'b1;
            next_irq_stat[mhiu_pkg::IRQ_ENG_DONE] = 1'b1;
            next_state = S_IDLE;
          end else begin
            next_idx = idx + 2'h1;
            next_key = LINK.cmd_op[idx + 2'h1];
            next_tick = 3'h0;
            next_state = S_INBUF;
          end
        end else begin
          next_cpu_op[jw] = obuf[1];
          next_cpu_pend = 1'b0;
          next_done_reg[mhiu_pkg::DONE_BIT] = 1'b1;
          next_irq_stat[mhiu_pkg::IRQ_CPU_DONE] = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // APB access phase
    if (PSEL_IN && PENABLE_IN && !pready) begin
      next_pready = 1'b1;
      next_prdata = 32'h0000_0000;
      if (ws != 2'h3) begin
        if (PWRITE_IN) begin
          // One processor hash at a time
          if (!cpu_pend) begin
            next_cpu_op[ws][wi*32 +: 32] = PWDATA_IN;
            next_done_reg = mhiu_pkg::DONE_RESET;
            if (wi == 2'h0) begin
              next_cpu_pend = 1'b1;
              next_cpu_w = mhiu_pkg::mhiu_width_t'(ws);
            end
          end else begin
            next_pslverr = 1'b1;
          end
        end else if (cpu_pend) begin
          next_pready = 1'b0;
        end else begin
          next_prdata = cpu_op[ws][wi*32 +: 32];
        end
      end else begin
        case (PADDR_IN)
          mhiu_pkg::OFF_DONE: next_prdata = done_reg;
          mhiu_pkg::OFF_IRQ_STAT: begin
            next_prdata = irq_stat;
            if (!PWRITE_IN) next_irq_stat = 32'h0000_0000;
          end
          mhiu_pkg::OFF_IRQ_MASK: begin
            next_prdata = irq_mask;
            if (PWRITE_IN) next_irq_mask = PWDATA_IN;
          end
          default: begin
            if (PADDR_IN[11:4] >= mhiu_pkg::OFF_MULT48[11:4] &&
                PADDR_IN[11:4] <= mhiu_pkg::OFF_MULT128[11:4]) begin
              next_prdata = mult[PADDR_IN[5:4] - 2'h1][wi*32 +: 32];
              if (PWRITE_IN) next_mult[PADDR_IN[5:4] - 2'h1][wi*32 +: 32] = PWDATA_IN;
            end else begin
              next_pslverr = 1'b1;
            end
          end
        endcase
      end
    end
    // Events win over the read-clear
    if (state == S_RETURN && from_eng && idx + 2'h1 >= cnt)
      next_irq_stat[mhiu_pkg::IRQ_ENG_DONE] = 1'b1;
    if (state == S_RETURN && !from_eng)
      next_irq_stat[mhiu_pkg::IRQ_CPU_DONE] = 1'b1;
    next_irq = |(next_irq_stat & irq_mask);
  end

  always_ff @(posedge LINK.clk) begin
    if (!LINK.rst_n) begin
      state <= S_IDLE;
      for (int i = 0; i < 3; i++) begin
        mult[i] <= mhiu_pkg::MULT_RESET;
        cpu_op[i] <= '0;
      end
      cpu_pend <= 1'b0;
      cpu_w <= mhiu_pkg::MHIU_W48;
      done_reg <= mhiu_pkg::DONE_RESET;
      irq_stat <= 32'h0000_0000;
      irq_mask <= mhiu_pkg::MASK_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      from_eng <= 1'b0;
      jw <= mhiu_pkg::MHIU_W48;
      idx <= 2'h0;
      cnt <= 2'h0;
      key <= '0;
      acc <= '0;
      obuf[0] <= '0;
      obuf[1] <= '0;
      step <= 4'h0;
      tick <= 3'h0;
      ready <= 1'b0;
      res_v <= 1'b0;
      res_i <= 2'h0;
      res_d <= '0;
      cdone <= 1'b0;
    end else begin
      state <= next_state;
      mult <= next_mult;
      cpu_op <= next_cpu_op;
      cpu_pend <= next_cpu_pend;
      cpu_w <= next_cpu_w;
      done_reg <= next_done_reg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
      from_eng <= next_from_eng;
      jw <= next_jw;
      idx <= next_idx;
      cnt <= next_cnt;
      key <= next_key;
      acc <= next_acc;
      obuf <= next_obuf;
      step <= next_step;
      tick <= next_tick;
      ready <= next_ready;
      res_v <= next_res_v;
      res_i <= next_res_i;
      res_d <= next_res_d;
      cdone <= next_cdone;
    end
  end

  assign LINK.cmd_ready = ready;
  assign LINK.res_valid = res_v;
  assign LINK.res_index = res_i;
  assign LINK.res_data = res_d;
  assign LINK.cmd_done = cdone;
  assign PRDATA_OUT = prdata;
  assign PREADY_OUT = pready;
  assign PSLVERR_OUT = pslverr;
  assign IRQ_OUT = irq;
endmodule : mhiu_unit
`default_nettype wire

// file: testbench/mhiu_asserts.sv
// Checker for the engine link of the hash unit.
// Assumes it sits beside mhiu_if, clocked by the link clock and reset.
`default_nettype none
module mhiu_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire mhiu_pkg::mhiu_width_t cmd_width,
  input wire logic [1:0] cmd_count,
  input wire logic [mhiu_pkg::KEY_W-1:0] cmd_op [mhiu_pkg::OPS_MAX],
  // Results
  input wire logic res_valid,
  input wire logic [1:0] res_index,
  input wire logic [mhiu_pkg::KEY_W-1:0] res_data,
  input wire logic cmd_done
);
  logic inflight;
  logic next_inflight;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Command taken and not yet finished
  always_comb begin
    next_inflight = inflight;
    if (cmd_ready) begin
      next_inflight = 1'b1;
    end else if (cmd_done) begin
      next_inflight = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inflight <= 1'b0;
    end else begin
      inflight <= next_inflight;
    end
  end
  sequence s_taken;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_array_min;
    !res_valid [*6];
  endsequence
  sequence s_array_long;
    !res_valid [*8];
  endsequence
  a_ready_has_req: assert property (cmd_ready |-> cmd_valid && !inflight)
    else $error("command accepted without a request");
  a_ready_pulse: assert property (s_taken |=> !cmd_ready)
    else $error("command accept held too long");
  a_count_legal: assert property (cmd_valid |-> cmd_count != 2'h0)
    else $error("command with zero operands");
  a_first_result_gap: assert property (s_taken |=> s_array_min)
    else $error("result came too soon");
  a_wide_result_gap: assert property ((s_taken ##0 cmd_width == mhiu_pkg::MHIU_W128)
    |=> s_array_long)
    else $error("wide result came too soon");
  a_narrow_index48: assert property (res_valid && cmd_width == mhiu_pkg::MHIU_W48
    |-> res_data[127:48] == 80'h0)
    else $error("short index has high bits");
  a_narrow_index64: assert property (res_valid && cmd_width == mhiu_pkg::MHIU_W64
    |-> res_data[127:64] == 64'h0)
    else $error("medium index has high bits");
  a_result_owner: assert property (res_valid |-> inflight && cmd_valid
    && res_index < cmd_count)
    else $error("result outside a command");
  a_done_after_last: assert property (cmd_done |-> inflight
    && (res_valid || $past(res_valid)))
    else $error("done without last result");
  a_done_bounded: assert property (s_taken |-> ##[1:300] cmd_done)
    else $error("command never finished");
  a_engine_holds: assert property (inflight && !cmd_done |=> cmd_valid
    && $stable(cmd_width) && $stable(cmd_op[0]))
    else $error("request dropped before done");
endmodule : mhiu_asserts
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench: unit and engine joined by mhiu_if, processor side over APB.
// Assumes the package, interface and both design ends are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    mhiu_pkg::mhiu_width_t w;
    logic [1:0] cnt;
    logic [127:0] op [3];
  } mhiu_row_t;
  logic clk = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, rerr;
  logic req_valid = 1'b0, req_busy, done;
  logic [1:0] req_width = 2'h0, req_count = 2'h0;
  logic [383:0] req_ops = '0, results, snap;
  logic [127:0] r, ref48;
  int miscompares = 0, n_compared = 0, rwait;
  mhiu_row_t rows [4];
  always #2.5 clk = ~clk;
  mhiu_if u_mhiu_if (.clk(clk), .rst_n(resetn_in));
  mhiu_unit u_mhiu_unit (.LINK(u_mhiu_if), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
  mhiu_engine u_mhiu_engine (.LINK(u_mhiu_if), .REQ_VALID_IN(req_valid),
    .REQ_WIDTH_IN(req_width), .REQ_COUNT_IN(req_count), .REQ_OPS_IN(req_ops),
    .REQ_BUSY_OUT(req_busy), .DONE_OUT(done), .RESULTS_OUT(results));
  mhiu_asserts u_mhiu_asserts (.clk(u_mhiu_if.clk), .rst_n(u_mhiu_if.rst_n),
    .cmd_valid(u_mhiu_if.cmd_valid), .cmd_ready(u_mhiu_if.cmd_ready),
    .cmd_width(u_mhiu_if.cmd_width), .cmd_count(u_mhiu_if.cmd_count),
    .cmd_op(u_mhiu_if.cmd_op), .res_valid(u_mhiu_if.res_valid),
    .res_index(u_mhiu_if.res_index), .res_data(u_mhiu_if.res_data),
    .cmd_done(u_mhiu_if.cmd_done));

  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk

  // One APB transfer; waits for the slave with no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    rwait = 0;
    do begin
      @(posedge clk);
      rwait++;
    end while (pready !== 1'b1 && rwait < 2000);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] base_of(input mhiu_pkg::mhiu_width_t w);
    return (w == mhiu_pkg::MHIU_W48) ? mhiu_pkg::OFF_OP48 :
      (w == mhiu_pkg::MHIU_W64) ? mhiu_pkg::OFF_OP64 : mhiu_pkg::OFF_OP128;
  endfunction : base_of

  task automatic cpu_hash(input mhiu_pkg::mhiu_width_t w, input logic [127:0] key,
                          output logic [127:0] res);
    int n;
    int t;
    n = (w == mhiu_pkg::MHIU_W128) ? 4 : 2;
    res = '0;
    for (int k = n - 1; k >= 0; k--) begin
      apb(1'b1, base_of(w) + 12'(4 * k), key[32*k+:32]);
    end
    t = 0;
    do begin
      apb(1'b0, mhiu_pkg::OFF_DONE, 32'h0000_0000);
      t++;
    end while (rdat !== 32'h0000_0001 && t < 200);
    chk("done flag", 128'h1, {96'h0, rdat});
    for (int k = 0; k < n; k++) begin
      apb(1'b0, base_of(w) + 12'(4 * k), 32'h0000_0000);
      res[32*k+:32] = rdat;
    end
    if (w != mhiu_pkg::MHIU_W128) begin
      chk("index high bits", '0, res >> ((w == mhiu_pkg::MHIU_W48) ? 48 : 64));
    end
  endtask : cpu_hash

  task automatic eng_run(input mhiu_row_t rw);
    int n;
    @(posedge clk);
    req_width <= 2'(rw.w);
    req_count <= rw.cnt;
    req_ops <= {rw.op[2], rw.op[1], rw.op[0]};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (req_busy === 1'b1) begin
        req_valid <= 1'b0;
      end
    end while (done !== 1'b1 && n < 500);
    chk("engine done", 128'h1, {127'h0, done});
    snap = results;
  endtask : eng_run

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    rows[0] = '{mhiu_pkg::MHIU_W48, 2'h1, '{128'h1234_5678_9abc, 128'h0, 128'h0}};
    rows[1] = '{mhiu_pkg::MHIU_W64, 2'h2, '{128'h0123_4567_89ab_cdef, 128'hffff_0000_ffff_0000,
      128'h0}};
    rows[2] = '{mhiu_pkg::MHIU_W128, 2'h3, '{128'hdead_beef_0000_1111_2222_3333_4444_5555,
      128'h1, '1}};
    rows[3] = '{mhiu_pkg::MHIU_W48, 2'h3, '{128'hffff_ffff_ffff, 128'h0, 128'h8000_0000_0001}};
    repeat (2) @(posedge clk);
    resetn_in <= 1'b1;
    foreach (rows[i]) begin
      eng_run(rows[i]);
      for (int j = 0; j < rows[i].cnt; j++) begin
        cpu_hash(rows[i].w, rows[i].op[j], r);
        chk("engine result", r, snap[128*j+:128]);
      end
    end
    // Interrupts: events pending while masked
    chk("irq masked", 128'h0, {127'h0, irq});
    apb(1'b0, mhiu_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq status", 128'h3, {96'h0, rdat});
    apb(1'b0, mhiu_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq status cleared", 128'h0, {96'h0, rdat});
    apb(1'b1, mhiu_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    cpu_hash(mhiu_pkg::MHIU_W48, rows[0].op[0], ref48);
    chk("irq raised", 128'h1, {127'h0, irq});
    apb(1'b0, mhiu_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq cpu bit", 128'h1, {96'h0, rdat});
    apb(1'b0, mhiu_pkg::OFF_IRQ_STAT, 32'h0000_0000);
    chk("irq dropped", 128'h0, {127'h0, irq});
    // Refused write and stalled read while a hash runs
    apb(1'b1, mhiu_pkg::OFF_OP48 + 12'h004, rows[0].op[0][63:32]);
    apb(1'b0, mhiu_pkg::OFF_DONE, 32'h0000_0000);
    chk("done cleared", 128'h0, {96'h0, rdat});
    apb(1'b1, mhiu_pkg::OFF_OP48, rows[0].op[0][31:0]);
    apb(1'b1, mhiu_pkg::OFF_OP48 + 12'h004, 32'h5555_5555);
    chk("busy write refused", 128'h1, {127'h0, rerr});
    apb(1'b0, mhiu_pkg::OFF_OP48, 32'h0000_0000);
    chk("stall seen", 128'h1, {127'h0, rwait > 2});
    chk("stalled read", {96'h0, ref48[31:0]}, {96'h0, rdat});
    apb(1'b0, mhiu_pkg::OFF_OP48 + 12'h004, 32'h0000_0000);
    chk("result high word", {96'h0, ref48[63:32]}, {96'h0, rdat});
    apb(1'b0, 12'h0fc, 32'h0000_0000);
    chk("unmapped", 128'h1_0000_0000, {95'h0, rerr, rdat});
    apb(1'b1, mhiu_pkg::OFF_MULT64, 32'h0000_0005);
    apb(1'b0, mhiu_pkg::OFF_MULT64, 32'h0000_0000);
    chk("multiplier write", 128'h5, {96'h0, rdat});
    // Second reset in mid-run
    @(posedge clk);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk);
    resetn_in <= 1'b1;
    apb(1'b0, mhiu_pkg::OFF_DONE, 32'h0000_0000);
    chk("done reset", 128'h0, {96'h0, rdat});
    apb(1'b0, mhiu_pkg::OFF_MULT64, 32'h0000_0000);
    chk("multiplier reset", 128'h1, {96'h0, rdat});
    apb(1'b0, mhiu_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    chk("mask reset", 128'h0, {96'h0, rdat});
    finish_test();
  end
endmodule : testbench
`default_nettype wire
